// ===== src/blarc_pkg.sv
// Package of constants and types for the lane aligner and refresh counter block
package blarc_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] BLARC_OFS_EVENT_COUNT = 8'h00;
  localparam logic [7:0] BLARC_OFS_TIMER_STATUS = 8'h04;
  localparam logic [7:0] BLARC_OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] BLARC_OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] BLARC_OFS_BUS_CONFIG = 8'h10;
  // Write keys
  localparam logic [5:0] BLARC_KEY_COUNT = 6'h29;
  localparam logic [7:0] BLARC_KEY_BYTE = 8'hA5;
  // Field positions
  localparam int BLARC_LIMIT_SEL_BIT = 2;
  localparam int BLARC_OVF_BIT = 7;
  // Reset values
  localparam logic [9:0] BLARC_COUNT_RESET = 10'h000;
  localparam logic [7:0] BLARC_STATUS_RESET = 8'h00;
  // Count limits selected by the limit-select bit
  localparam logic [9:0] BLARC_LIMIT_LOW = 10'h3FF;
  localparam logic [9:0] BLARC_LIMIT_HIGH = 10'h1FF;
  // Access size encoding
  typedef enum logic [1:0] {
    BLARC_SZ_BYTE = 2'b00,
    BLARC_SZ_WORD = 2'b01,
    BLARC_SZ_LONG = 2'b10
  } blarc_size_t;
  // Memory types
  typedef enum logic [2:0] {
    BLARC_MEM_NORMAL = 3'h0,
    BLARC_MEM_DRAM = 3'h1,
    BLARC_MEM_PSRAM = 3'h2,
    BLARC_MEM_SDRAM = 3'h3,
    BLARC_MEM_PCMCIA = 3'h4
  } blarc_mem_t;
  // Aligner states, Gray along the usual path
  typedef enum logic [1:0] {
    BLARC_ST_IDLE = 2'b00,
    BLARC_ST_XFER = 2'b01,
    BLARC_ST_WAIT = 2'b11,
    BLARC_ST_DONE = 2'b10
  } blarc_state_t;
endpackage

// ===== src/blarc_refresh.sv
// Refresh event counter with keyed write and overflow detection
`timescale 1ns/1ps
module blarc_refresh
  import blarc_pkg::*;
(
  // Clock and control
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic por_i,
  input wire logic match_i,
  input wire logic limit_sel_i,
  // Keyed write
  input wire logic wr_i,
  input wire logic [9:0] wr_data_i,
  // State
  output logic [9:0] count_o,
  output logic ovf_pulse_o
);
  typedef struct packed {
    logic [9:0] count;
    logic ovf;
  } blarc_rf_t;
  blarc_rf_t st;
  blarc_rf_t next_st;
  logic [9:0] limit;

  // Counter update
  always_comb
  begin
    next_st = st;
    next_st.ovf = 1'b0;
    limit = limit_sel_i ? BLARC_LIMIT_HIGH : BLARC_LIMIT_LOW;
    if (wr_i)
    begin
      next_st.count = wr_data_i;
    end
    else if (match_i)
    begin
      if (st.count >= limit)
      begin
        next_st.count = BLARC_COUNT_RESET;
        next_st.ovf = 1'b1;
      end
      else
      begin
        next_st.count = st.count + 10'h001;
      end
    end
  end

  // Only power-on reset clears the count
  always_ff @(posedge clock_i)
  begin
    if (srst_i && por_i)
    begin
      st <= '{count: BLARC_COUNT_RESET, ovf: 1'b0};
    end
    else if (srst_i)
    begin
      st.ovf <= 1'b0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  assign count_o = st.count;
  assign ovf_pulse_o = st.ovf;
endmodule

// ===== src/blarc_lanes.sv
// Lane steering and strobe generation for one external bus beat
`timescale 1ns/1ps
module blarc_lanes
  import blarc_pkg::*;
(
  // Beat description
  input wire logic little_i,
  input wire logic [1:0] width_i,
  input wire logic [1:0] beat_size_i,
  input wire logic [1:0] beat_ofs_i,
  input wire logic [31:0] beat_data_i,
  // Lane outputs
  output logic [31:0] lane_data_o,
  output logic [3:0] lane_strobe_o,
  output logic [1:0] lane_pos_o
);
  logic [1:0] pos;

  // Lane index of the beat's lowest lane
  always_comb
  begin
    pos = 2'd0;
    lane_strobe_o = 4'h0;
    if (width_i == BLARC_SZ_BYTE)
    begin
      pos = 2'd0;
      lane_strobe_o = 4'h1;
    end
    else if (width_i == BLARC_SZ_WORD)
    begin
      if (beat_size_i == BLARC_SZ_BYTE)
      begin
        pos = little_i ? {1'b0, beat_ofs_i[0]} : {1'b0, ~beat_ofs_i[0]};
        lane_strobe_o = 4'h1 << pos;
      end
      else
      begin
        pos = 2'd0;
        lane_strobe_o = 4'h3;
      end
    end
    else
    begin
      if (beat_size_i == BLARC_SZ_BYTE)
      begin
        pos = little_i ? beat_ofs_i : ~beat_ofs_i;
        lane_strobe_o = 4'h1 << pos;
      end
      else if (beat_size_i == BLARC_SZ_WORD)
      begin
        pos = little_i ? {beat_ofs_i[1], 1'b0} : {~beat_ofs_i[1], 1'b0};
        lane_strobe_o = 4'h3 << pos;
      end
      else
      begin
        pos = 2'd0;
        lane_strobe_o = 4'hF;
      end
    end
  end

  assign lane_data_o = beat_data_i << {pos, 3'b000};
  assign lane_pos_o = pos;
endmodule

// ===== src/blarc_top.sv
// Bus lane aligner with access splitting and refresh event counter registers
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module blarc_top
  import blarc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic por_i,
  input wire logic endian_select_pin_i,
  // Refresh timer events and status
  input wire logic refresh_match_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_word_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic irq_o,
  // Core access request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire blarc_pkg::blarc_size_t req_size_i,
  input wire logic [1:0] req_ofs_i,
  input wire logic [31:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_error_o,
  output logic [31:0] rsp_rdata_o,
  // External bus beat
  output logic ext_valid_o,
  output logic ext_write_o,
  output logic [1:0] ext_ofs_o,
  output logic [31:0] ext_wdata_o,
  output logic [3:0] write_strobe_o,
  output logic [3:0] column_strobe_o,
  output logic [3:0] data_mask_o,
  input wire logic ext_ack_i,
  input wire logic [31:0] ext_rdata_i
);
  // Whole block state, registered as one record
  typedef struct packed {
    logic little;
    logic [7:0] timer_status;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [2:0] mem_type;
    logic [1:0] width;
    logic [15:0] rdata;
    blarc_state_t state;
    logic write;
    logic [1:0] size;
    logic [1:0] base;
    logic [1:0] beat;
    logic [1:0] beats_m1;
    logic [31:0] wdata;
    logic [31:0] acc;
    logic rsp_valid;
    logic rsp_error;
    logic [31:0] rsp_data;
    logic [31:0] bus_data;
    logic [3:0] strobe;
  } blarc_st_t;

  // Internal nets between the parts
  blarc_st_t st;
  blarc_st_t next_st;
  logic key_ok_count;
  logic key_ok_byte;
  logic cnt_wr;
  logic [9:0] count;
  logic ovf_pulse;
  logic [1:0] beat_size;
  logic [1:0] beat_ofs;
  logic [31:0] beat_src;
  logic [31:0] lane_data;
  logic [3:0] lane_strobe;
  logic [1:0] lane_pos;
  logic [31:0] beat_rd;
  logic width_ok;
  logic [4:0] sh;

  // Key checks for refresh register writes
  assign key_ok_count = reg_word_i && reg_wdata_i[15:10] == BLARC_KEY_COUNT;
  assign key_ok_byte = reg_word_i && reg_wdata_i[15:8] == BLARC_KEY_BYTE;
  assign cnt_wr = reg_wr_i && reg_addr_i == BLARC_OFS_EVENT_COUNT && key_ok_count;

  // Refresh counter
  blarc_refresh u_refresh (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .por_i(por_i),
    .match_i(refresh_match_i),
    .limit_sel_i(st.timer_status[BLARC_LIMIT_SEL_BIT]),
    .wr_i(cnt_wr),
    .wr_data_i(reg_wdata_i[9:0]),
    .count_o(count),
    .ovf_pulse_o(ovf_pulse)
  );

  // Width permitted for the configured memory type
  always_comb
  begin
    case (blarc_mem_t'(st.mem_type))
      BLARC_MEM_NORMAL: width_ok = st.width != 2'b11;
      BLARC_MEM_DRAM, BLARC_MEM_PSRAM: width_ok = st.width != BLARC_SZ_BYTE
        && st.width != 2'b11;
      BLARC_MEM_SDRAM: width_ok = st.width == BLARC_SZ_LONG;
      BLARC_MEM_PCMCIA: width_ok = st.width != BLARC_SZ_LONG && st.width != 2'b11;
      default: width_ok = 1'b0;
    endcase
  end

  // Beat size is the smaller of access and device width
  assign beat_size = (st.size > st.width) ? st.width : st.size;
  // Piece size as a shift count, 8 or 16 bits
  assign sh = (beat_size == BLARC_SZ_BYTE) ? 5'd3 : 5'd4;
  assign beat_ofs = st.base + ((beat_size == BLARC_SZ_BYTE) ? st.beat : {st.beat[0], 1'b0});
  // Big endian sends the most significant piece first
  assign beat_src = st.little
    ? (st.wdata >> ({3'b000, st.beat} << sh))
    : (st.wdata >> ({3'b000, st.beats_m1 - st.beat} << sh));

  // Lane steering for the current beat
  blarc_lanes u_lanes (
    .little_i(st.little),
    .width_i(st.width),
    .beat_size_i(beat_size),
    .beat_ofs_i(beat_ofs),
    .beat_data_i(beat_src),
    .lane_data_o(lane_data),
    .lane_strobe_o(lane_strobe),
    .lane_pos_o(lane_pos)
  );
  // Read lanes shifted down to bit zero
  assign beat_rd = ext_rdata_i >> {lane_pos, 3'b000};

  // Register, aligner and interrupt next state
  always_comb
  begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.rdata = 16'h0000;
    // Sticky events, set wins over clear
    if (reg_wr_i && reg_addr_i == BLARC_OFS_IRQ_STATUS)
    begin
      next_st.irq_status = st.irq_status & ~reg_wdata_i[1:0];
    end
    if (reg_wr_i && reg_addr_i == BLARC_OFS_TIMER_STATUS && key_ok_byte)
    begin
      next_st.timer_status = reg_wdata_i[7:0];
    end
    else if (reg_wr_i && reg_addr_i == BLARC_OFS_IRQ_MASK)
    begin
      next_st.irq_mask = reg_wdata_i[1:0];
    end
    else if (reg_wr_i && reg_addr_i == BLARC_OFS_BUS_CONFIG)
    begin
      next_st.mem_type = reg_wdata_i[4:2];
      next_st.width = reg_wdata_i[1:0];
    end
    if (ovf_pulse)
    begin
      next_st.timer_status[BLARC_OVF_BIT] = 1'b1;
      next_st.irq_status[0] = 1'b1;
    end
    // Register read, undefined bits zero
    if (reg_rd_i)
    begin
      if (reg_addr_i == BLARC_OFS_EVENT_COUNT)
      begin
        next_st.rdata = {6'h00, count};
      end
      else if (reg_addr_i == BLARC_OFS_TIMER_STATUS)
      begin
        next_st.rdata = {8'h00, st.timer_status};
      end
      else if (reg_addr_i == BLARC_OFS_IRQ_STATUS)
      begin
        next_st.rdata = {14'h0000, st.irq_status};
      end
      else if (reg_addr_i == BLARC_OFS_IRQ_MASK)
      begin
        next_st.rdata = {14'h0000, st.irq_mask};
      end
      else if (reg_addr_i == BLARC_OFS_BUS_CONFIG)
      begin
        next_st.rdata = {11'h000, st.mem_type, st.width};
      end
      else
      begin
        next_st.rdata = 16'h0000;
      end
    end
    // Access splitting state machine
    case (st.state)
      BLARC_ST_IDLE:
      begin
        // Latch the request and plan its beats
        if (req_valid_i)
        begin
          next_st.write = req_write_i;
          next_st.size = req_size_i;
          next_st.base = req_ofs_i;
          next_st.wdata = req_wdata_i;
          next_st.acc = 32'h0000_0000;
          next_st.beat = 2'd0;
          if (!width_ok)
          begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_error = 1'b1;
          end
          else
          begin
            next_st.rsp_error = 1'b0;
            next_st.state = BLARC_ST_XFER;
            if (req_size_i > st.width)
            begin
              next_st.beats_m1 = (req_size_i == BLARC_SZ_LONG && st.width == BLARC_SZ_BYTE)
                ? 2'd3 : 2'd1;
            end
            else
            begin
              next_st.beats_m1 = 2'd0;
            end
          end
        end
      end
      BLARC_ST_XFER:
      begin
        // Drive lanes and strobes for the whole beat
        next_st.bus_data = lane_data;
        next_st.strobe = lane_strobe;
        next_st.state = BLARC_ST_WAIT;
      end
      BLARC_ST_WAIT:
      begin
        if (ext_ack_i)
        begin
          next_st.strobe = 4'h0;
          // Reassemble in the order the pieces arrive
          if (beat_size == BLARC_SZ_BYTE)
          begin
            next_st.acc = st.little
              ? st.acc | ({24'h00_0000, beat_rd[7:0]} << ({3'b000, st.beat} << sh))
              : {st.acc[23:0], beat_rd[7:0]};
          end
          else
          begin
            next_st.acc = st.little
              ? st.acc | ({16'h0000, beat_rd[15:0]} << ({3'b000, st.beat} << sh))
              : {st.acc[15:0], beat_rd[15:0]};
          end
          if (st.beat == st.beats_m1)
          begin
            next_st.state = BLARC_ST_DONE;
          end
          else
          begin
            next_st.beat = st.beat + 2'd1;
            next_st.state = BLARC_ST_XFER;
          end
        end
      end
      BLARC_ST_DONE:
      begin
        // One-cycle response with the assembled data
        next_st.rsp_valid = 1'b1;
        next_st.rsp_data = st.acc;
        next_st.state = BLARC_ST_IDLE;
      end
      default:
      begin
        next_st.state = BLARC_ST_IDLE;
      end
    endcase
  end

  // State register; endian pin caught only at power-on reset
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      if (por_i)
      begin
        st <= '0;
        st.little <= endian_select_pin_i;
        st.timer_status <= BLARC_STATUS_RESET;
      end
      else
      begin
        // Manual reset aborts the access, keeps count and settings
        st.state <= BLARC_ST_IDLE;
        st.rdata <= 16'h0000;
        st.rsp_valid <= 1'b0;
        st.strobe <= 4'h0;
      end
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // Outputs
  assign req_ready_o = st.state == BLARC_ST_IDLE;
  assign reg_rdata_o = st.rdata;
  assign irq_o = |(st.irq_status & st.irq_mask);
  assign rsp_valid_o = st.rsp_valid;
  assign rsp_error_o = st.rsp_error;
  assign rsp_rdata_o = st.rsp_data;
  assign ext_valid_o = st.state == BLARC_ST_WAIT;
  assign ext_write_o = st.write;
  assign ext_ofs_o = beat_ofs;
  assign ext_wdata_o = st.bus_data;
  assign write_strobe_o = st.write ? st.strobe : 4'h0;
  assign column_strobe_o = st.strobe;
  assign data_mask_o = ~st.strobe;
endmodule

// ===== bench/blarc_assertions.sv
// Port checker for the lane aligner and refresh counter top
`timescale 1ns/1ps
module blarc_assertions
  import blarc_pkg::*;
(
  // Watched ports
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic ext_valid_o,
  input wire logic ext_write_o,
  input wire logic [1:0] ext_ofs_o,
  input wire logic [3:0] write_strobe_o,
  input wire logic [3:0] column_strobe_o,
  input wire logic [3:0] data_mask_o,
  input wire logic ext_ack_i
);
  // One clock domain
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  idle_read_zero_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data not zero");
  count_key_zero_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == BLARC_OFS_EVENT_COUNT |-> reg_rdata_o[15:10] == 6'h00)
    else $error("count key bits not zero");
  mask_clear_irq_a: assert property (
    reg_wr_i && reg_addr_i == BLARC_OFS_IRQ_MASK && reg_wdata_i == 16'h0000 |=> !irq_o)
    else $error("irq high with mask clear");
  beat_hold_a: assert property (
    ext_valid_o && !ext_ack_i |=> ext_valid_o && $stable(ext_ofs_o) && $stable(column_strobe_o)
    && $stable(ext_write_o)) else $error("beat changed before ack");
  mask_inverse_a: assert property (
    ext_valid_o |-> data_mask_o == ~column_strobe_o
    && column_strobe_o inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
    else $error("mask or lane strobe pattern wrong");
  strobe_present_a: assert property (
    ext_valid_o |-> column_strobe_o != 4'h0) else $error("beat without strobe");
  write_lanes_a: assert property (
    ext_valid_o && ext_write_o |-> write_strobe_o == column_strobe_o)
    else $error("write strobe differs from lane strobe");
  rsp_bound_a: assert property (
    req_valid_i && req_ready_o |-> ##[1:60] rsp_valid_o) else $error("no response");
  rsp_after_beat_a: assert property (
    rsp_valid_o |-> !ext_valid_o) else $error("response during beat");
endmodule

bind blarc_top blarc_assertions u_chk (.clock_i(clock_i), .srst_i(srst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .ext_valid_o(ext_valid_o),
  .ext_write_o(ext_write_o), .ext_ofs_o(ext_ofs_o), .write_strobe_o(write_strobe_o),
  .column_strobe_o(column_strobe_o), .data_mask_o(data_mask_o), .ext_ack_i(ext_ack_i));

// ===== bench/blarc_ext_model.sv
// Behavioural external device answering bus beats
`timescale 1ns/1ps
module blarc_ext_model
(
  // Beat from the block
  input wire logic clock_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic write_i,
  input wire logic [1:0] ofs_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] strobe_i,
  // Answer
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [4];
  logic [3:0] strb [4];
  logic [1:0] cnt = 2'd0;
  logic [31:0] m;
  initial ack_o = 1'b0;
  initial rdata_o = 32'h5A5A_0F0F;
  assign m = {{8{strobe_i[3]}}, {8{strobe_i[2]}}, {8{strobe_i[1]}}, {8{strobe_i[0]}}};
  // Ack at once or after three waits; unstrobed lanes carry noise
  always @(posedge clock_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (valid_i && !ack_o)
    begin
      cnt <= cnt + 2'd1;
      if (cnt == (slow_i ? 2'd3 : 2'd0))
      begin
        ack_o <= 1'b1;
        cnt <= 2'd0;
        strb[ofs_i] <= strobe_i;
        if (write_i)
          mem[ofs_i] <= wdata_i;
        else
          rdata_o <= (mem[ofs_i] & m) | (~mem[ofs_i] & ~m);
      end
    end
  end
endmodule

// ===== bench/testbench.sv
// Register, refresh count and lane alignment tests of the block
`timescale 1ns/1ps
module testbench;
  import blarc_pkg::*;
  logic clk = 0, srst = 1, por = 1, pin = 0, match = 0, slow = 0, ce = 1;
  logic [7:0] addr = 0;
  logic [15:0] wd = 0, rdata;
  logic word = 0, wr = 0, rd = 0, irq, rv = 0, ready, rw = 0, rspv, rspe, ev, ew, ack;
  blarc_size_t rs = BLARC_SZ_BYTE;
  logic [1:0] ro = 0, eo;
  logic [31:0] rwd = 0, rsd, ewd, erd, q;
  logic [3:0] wst, cst, dm;
  logic e;
  int n_errors = 0, checks = 0;
  blarc_top dut (.clock_i(clk), .srst_i(srst), .ce_i(ce), .por_i(por),
    .endian_select_pin_i(pin), .refresh_match_i(match), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_word_i(word), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
    .req_valid_i(rv), .req_ready_o(ready), .req_write_i(rw), .req_size_i(rs), .req_ofs_i(ro),
    .req_wdata_i(rwd), .rsp_valid_o(rspv), .rsp_error_o(rspe), .rsp_rdata_o(rsd),
    .ext_valid_o(ev), .ext_write_o(ew), .ext_ofs_o(eo), .ext_wdata_o(ewd),
    .write_strobe_o(wst), .column_strobe_o(cst), .data_mask_o(dm), .ext_ack_i(ack),
    .ext_rdata_i(erd));
  blarc_ext_model pm (.clock_i(clk), .slow_i(slow), .valid_i(ev), .write_i(ew), .ofs_i(eo),
    .wdata_i(ewd), .strobe_i(cst), .ack_o(ack), .rdata_o(erd));
  always #2 clk = ~clk;
  // Verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reset(input logic p, input logic l);
    srst <= 1'b1;
    por <= p;
    pin <= l;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    por <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    addr <= a;
    wd <= d;
    word <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(32'(rdata), 32'(x));
  endtask
  task automatic pulse();
    @(posedge clk);
    match <= 1'b1;
    @(posedge clk);
    match <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] mt, input logic [1:0] w);
    wreg(BLARC_OFS_BUS_CONFIG, {11'h000, mt, w}, 1'b1);
  endtask
  // One core access, held until taken, then the bounded wait for its answer
  task automatic acc(input logic w, input blarc_size_t s, input logic [1:0] o,
    input logic [31:0] d);
    int i;
    @(posedge clk);
    rv <= 1'b1;
    rw <= w;
    rs <= s;
    ro <= o;
    rwd <= d;
    // Ready settles mid-cycle; the request is taken at the next edge
    #1;
    for (i = 0; i < 60 && ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (ready === 1'b1)
    begin
      @(posedge clk);
      rv <= 1'b0;
      for (i = 0; i < 80; i++)
      begin
        #1;
        if (rspv === 1'b1) break;
        @(posedge clk);
      end
    end
    else
      i = 80;
    if (i == 80)
    begin
      n_errors++;
      results();
    end
    else
    begin
      q = rsd;
      e = rspe;
    end
  endtask
  task automatic lane(input int o, input logic [3:0] s, input logic [31:0] x);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    chk(32'(pm.strb[o]), 32'(s));
    chk(pm.mem[o] & m, x);
  endtask
  initial
  begin
    reset(1'b1, 1'b0);
    rreg(BLARC_OFS_EVENT_COUNT, 16'h0000);
    wreg(BLARC_OFS_EVENT_COUNT, {BLARC_KEY_COUNT, 10'h1FE}, 1'b1);
    rreg(BLARC_OFS_EVENT_COUNT, 16'h01FE);
    wreg(BLARC_OFS_EVENT_COUNT, {6'h2A, 10'h005}, 1'b1);
    wreg(BLARC_OFS_EVENT_COUNT, {BLARC_KEY_COUNT, 10'h005}, 1'b0);
    rreg(BLARC_OFS_EVENT_COUNT, 16'h01FE);
    wreg(BLARC_OFS_TIMER_STATUS, {BLARC_KEY_BYTE, 8'h04}, 1'b1);
    wreg(BLARC_OFS_TIMER_STATUS, 16'h5A00, 1'b1);
    rreg(BLARC_OFS_TIMER_STATUS, 16'h0004);
    pulse();
    rreg(BLARC_OFS_EVENT_COUNT, 16'h01FF);
    wreg(BLARC_OFS_IRQ_MASK, 16'h0001, 1'b1);
    pulse();
    rreg(BLARC_OFS_EVENT_COUNT, 16'h0000);
    rreg(BLARC_OFS_TIMER_STATUS, 16'h0084);
    chk(32'(irq), 32'h1);
    wreg(BLARC_OFS_IRQ_MASK, 16'h0000, 1'b1);
    #1 chk(32'(irq), 32'h0);
    wreg(BLARC_OFS_IRQ_STATUS, 16'h0001, 1'b1);
    wreg(BLARC_OFS_IRQ_MASK, 16'h0001, 1'b1);
    rreg(BLARC_OFS_IRQ_STATUS, 16'h0000);
    chk(32'(irq), 32'h0);
    wreg(BLARC_OFS_TIMER_STATUS, {BLARC_KEY_BYTE, 8'h00}, 1'b1);
    wreg(BLARC_OFS_EVENT_COUNT, {BLARC_KEY_COUNT, 10'h1FF}, 1'b1);
    pulse();
    rreg(BLARC_OFS_EVENT_COUNT, 16'h0200);
    wreg(BLARC_OFS_EVENT_COUNT, {BLARC_KEY_COUNT, 10'h3FF}, 1'b1);
    pulse();
    rreg(BLARC_OFS_EVENT_COUNT, 16'h0000);
    rreg(8'h20, 16'h0000);
    wreg(BLARC_OFS_EVENT_COUNT, {BLARC_KEY_COUNT, 10'h123}, 1'b1);
    ce <= 1'b0;
    pulse();
    ce <= 1'b1;
    reset(1'b0, 1'b1);
    rreg(BLARC_OFS_EVENT_COUNT, 16'h0123);
    cfg(3'h0, 2'd2);
    for (int k = 0; k < 4; k++)
    begin
      acc(1'b1, BLARC_SZ_BYTE, 2'(k), 32'h0000_00AB);
      lane(k, 4'b1000 >> k, 32'hAB00_0000 >> (8 * k));
    end
    acc(1'b1, BLARC_SZ_WORD, 2'd0, 32'h0000_1234);
    lane(0, 4'hC, 32'h1234_0000);
    acc(1'b1, BLARC_SZ_WORD, 2'd2, 32'h0000_5678);
    lane(2, 4'h3, 32'h0000_5678);
    acc(1'b1, BLARC_SZ_LONG, 2'd0, 32'h89AB_CDEF);
    lane(0, 4'hF, 32'h89AB_CDEF);
    cfg(3'h0, 2'd1);
    acc(1'b1, BLARC_SZ_BYTE, 2'd0, 32'h0000_00AB);
    lane(0, 4'h2, 32'h0000_AB00);
    acc(1'b1, BLARC_SZ_BYTE, 2'd1, 32'h0000_00CD);
    lane(1, 4'h1, 32'h0000_00CD);
    acc(1'b1, BLARC_SZ_LONG, 2'd0, 32'h1122_3344);
    lane(0, 4'h3, 32'h0000_1122);
    lane(2, 4'h3, 32'h0000_3344);
    acc(1'b0, BLARC_SZ_LONG, 2'd0, 32'h0);
    chk(q, 32'h1122_3344);
    cfg(3'h0, 2'd0);
    slow <= 1'b1;
    acc(1'b1, BLARC_SZ_LONG, 2'd0, 32'h5566_7788);
    for (int k = 0; k < 4; k++)
      lane(k, 4'h1, 32'h0000_0055 + 32'(k) * 32'h11);
    acc(1'b0, BLARC_SZ_LONG, 2'd0, 32'h0);
    chk(q, 32'h5566_7788);
    slow <= 1'b0;
    cfg(3'h3, 2'd0);
    acc(1'b0, BLARC_SZ_BYTE, 2'd0, 32'h0);
    chk(32'(e), 32'h1);
    cfg(3'h4, 2'd2);
    acc(1'b0, BLARC_SZ_BYTE, 2'd0, 32'h0);
    chk(32'(e), 32'h1);
    cfg(3'h1, 2'd2);
    acc(1'b0, BLARC_SZ_BYTE, 2'd0, 32'h0);
    chk(32'(e), 32'h0);
    @(posedge clk);
    reset(1'b1, 1'b1);
    rreg(BLARC_OFS_EVENT_COUNT, 16'h0000);
    cfg(3'h0, 2'd2);
    for (int k = 0; k < 4; k++)
    begin
      acc(1'b1, BLARC_SZ_BYTE, 2'(k), 32'h0000_00AB);
      lane(k, 4'b0001 << k, 32'h0000_00AB << (8 * k));
    end
    results();
  end
endmodule
